// >>> bench/edfe_assertions.sv
`timescale 1ns/100ps
`include "edfe_defs.svh"
module edfe_assertions (
    // System
    input wire logic clk_sys,
    input wire logic rst_b,
    // Core and access ports
    input wire logic [7:0] ap_sel,
    input wire logic halt_cmd,
    input wire logic core_halt,
    input wire logic core_reset_req,
    input wire logic ahb_ap_sel,
    input wire logic mgr_ap_sel,
    // AXI4-Lite
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [7:0] rd_addr_reg;
    wire rd_map = rd_addr_reg == `EDFE_OFF_CTRL || rd_addr_reg == `EDFE_OFF_STAT || rd_addr_reg == `EDFE_OFF_LENGTH;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) rd_addr_reg <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
    end
    ////////////////////////////////////////
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    a_resp_one: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    a_len_low: assert property (
        s_axi_rvalid && rd_addr_reg == `EDFE_OFF_LENGTH |-> s_axi_rdata[1:0] == 2'h0) else $error("length low bits");
    a_unmapped_err: assert property (
        s_axi_rvalid && !rd_map |-> s_axi_rresp == `EDFE_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped");
    a_ap_onehot: assert property (!(ahb_ap_sel && mgr_ap_sel))
        else $error("two access ports selected");
    a_ap_decode: assert property (
        (ahb_ap_sel |-> $past(ap_sel, 3) == 8'h00) and (mgr_ap_sel |-> $past(ap_sel, 3) == 8'h01))
        else $error("access port select does not match its number");
    a_req_hold: assert property (
        $fell(core_reset_req) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("reset request dropped without release write");
    a_halt_cause: assert property (!halt_cmd [*5] |=> !core_halt)
        else $error("core halted without command");
    c_release: cover property ($fell(core_reset_req));
    c_mgr: cover property (mgr_ap_sel);
    c_err: cover property (s_axi_rvalid && !rd_map);
endmodule
bind edfe_top edfe_assertions u_chk (.clk_sys, .rst_b, .ap_sel, .halt_cmd, .core_halt, .core_reset_req, .ahb_ap_sel,
    .mgr_ap_sel, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_bvalid, .s_axi_bready);

// >>> bench/edfe_probe.sv
`timescale 1ns/100ps
module edfe_probe (
    // Link
    output logic link_clk,
    output logic ext_reset_b,
    output logic link_tms_in,
    output logic link_tdi_in,
    output logic link_swd_req,
    output logic link_tdo_data,
    output logic trace_data
);
    // The probe parks its clock low between frames; it never free-runs.
    initial begin
        link_clk = 1'h0;
        ext_reset_b = 1'h1;
        link_tms_in = 1'h1;
        link_tdi_in = 1'h0;
        link_swd_req = 1'h0;
        link_tdo_data = 1'h0;
    end
    // Trace is always the inverse of data out, so a wrong mux choice shows.
    assign trace_data = ~link_tdo_data;
    task automatic pulse(input int n);
        repeat (n) begin
            #16 link_clk = 1'h1;
            #16 link_clk = 1'h0;
            link_tms_in = ~link_tms_in;
            link_tdi_in = ~link_tdi_in;
            link_tdo_data = ~link_tdo_data;
        end
    endtask
    task automatic connect(input logic hold_low);
        #2 ext_reset_b = 1'h0;
        #7;
        if (!hold_low) pulse(3);
        #100 ext_reset_b = 1'h1;
        #40 pulse(6);
    endtask
    task automatic to_serial();
        pulse(8);
        link_swd_req = 1'h1;
        pulse(4);
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
`include "edfe_defs.svh"
module testbench;
    import edfe_pkg::*;
    localparam logic op_rd = 1'h0, op_wr = 1'h1;
    logic clk_sys = 1'h0, rst_b = 1'h0, ap_req = 1'h0, halt_cmd = 1'h0;
    logic [7:0] ap_sel = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ahb_ap_sel, mgr_ap_sel, core_reset_req, core_halt;
    logic link_clk, ext_reset_b, link_tms_in, link_tdi_in, link_swd_req, link_tdo_data, trace_data;
    edfe_pins_s gpio_out = 4'hA, gpio_oe = 4'h0, pin_out, pin_oe;
    int err_count = 0, checked = 0;
    edfe_top dut (.clk_sys, .rst_b, .ext_reset_b, .link_clk, .link_tms_in, .link_tdi_in, .link_swd_req,
        .link_tdo_data, .trace_data, .ap_sel, .ap_req, .gpio_out, .gpio_oe, .pin_out, .pin_oe, .ahb_ap_sel,
        .mgr_ap_sel, .core_reset_req, .core_halt, .halt_cmd, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    edfe_probe u_probe (.link_clk, .ext_reset_b, .link_tms_in, .link_tdi_in, .link_swd_req, .link_tdo_data,
        .trace_data);
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) $display("MISMATCH %s expected %h seen %h", what, exp, got);
        if (got !== exp) err_count++;
    endtask
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        for (int n = 0; n < 400 && s !== v; n++) @(posedge clk_sys);
        chk("wait", 32'(v), 32'(s));
        if (s !== v) test_done();
    endtask
    // One task serves both directions; d is write data or expected read data.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        done = 1'h0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid || s_axi_rvalid) begin
                done = 1'h1;
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                if (!w) chk("rdata", d, s_axi_rdata);
                chk("resp", 32'(er), 32'(w ? s_axi_bresp : s_axi_rresp));
            end
        end
        chk("answer", 32'h1, 32'(done));
        if (!done) test_done();
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        xfer(op_rd, `EDFE_OFF_CTRL, 32'h1, `EDFE_RESP_OKAY);
        xfer(op_rd, `EDFE_OFF_STAT, 32'h0, `EDFE_RESP_OKAY);
        xfer(op_rd, `EDFE_OFF_LENGTH, `EDFE_LENGTH_RST, `EDFE_RESP_OKAY);
        xfer(op_wr, `EDFE_OFF_LENGTH, 32'hFFFF_FFFF, `EDFE_RESP_OKAY);
        xfer(op_rd, `EDFE_OFF_LENGTH, 32'hFFFF_FFFC, `EDFE_RESP_OKAY);
        xfer(op_wr, 8'h20, 32'hFFFF_FFFF, `EDFE_RESP_SLVERR);
        xfer(op_rd, 8'h20, 32'h0, `EDFE_RESP_SLVERR);
    endtask
    task automatic t_core_req();
        u_probe.connect(1'h1);
        wait_for(core_reset_req, 1'h1);
        repeat (60) @(posedge clk_sys);
        chk("req_held", 32'h1, 32'(core_reset_req));
        chk("no_halt", 32'h0, 32'(core_halt));
        xfer(op_rd, `EDFE_OFF_STAT, 32'hB, `EDFE_RESP_OKAY);
        halt_cmd <= 1'h1;
        wait_for(core_halt, 1'h1);
        halt_cmd <= 1'h0;
        xfer(op_wr, `EDFE_OFF_CTRL, 32'h3, `EDFE_RESP_OKAY);
        wait_for(core_reset_req, 1'h0);
    endtask
    task automatic t_ap_sel();
        for (int s = 0; s < 3; s++) begin
            ap_sel <= 8'(s);
            ap_req <= 1'h1;
            repeat (10) @(posedge clk_sys);
            chk("ahb_sel", 32'(s == 0), 32'(ahb_ap_sel));
            chk("mgr_sel", 32'(s == 1), 32'(mgr_ap_sel));
        end
    endtask
    task automatic t_pins();
        u_probe.connect(1'h0);
        repeat (60) @(posedge clk_sys);
        chk("no_req", 32'h0, 32'(core_reset_req));
        gpio_out <= ~{link_tms_in, link_tdi_in, link_tdo_data, 1'h0};
        gpio_oe <= 4'h5;
        xfer(op_wr, `EDFE_OFF_CTRL, 32'h9, `EDFE_RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        chk("jtag_tdo", 32'(link_tdo_data), 32'(pin_out.tdo_trace));
        chk("jtag_oe", 32'h1, 32'(pin_oe.tdo_trace));
        u_probe.to_serial();
        xfer(op_wr, `EDFE_OFF_CTRL, 32'h9, `EDFE_RESP_OKAY);
        xfer(op_rd, `EDFE_OFF_STAT, 32'hD, `EDFE_RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        chk("swd_trace", 32'(trace_data), 32'(pin_out.tdo_trace));
        xfer(op_wr, `EDFE_OFF_CTRL, 32'h0, `EDFE_RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        chk("gpio_out", 32'(gpio_out), 32'(pin_out));
        chk("gpio_oe", 32'(gpio_oe), 32'(pin_oe));
    endtask
    initial begin
        u_probe.pulse(2);
        repeat (14) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_core_req();
        t_ap_sel();
        t_pins();
        test_done();
    end
endmodule

// >>> design/edfe_top.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "edfe_defs.svh"
module edfe_top (
    // System
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ext_reset_b,
    // Link
    input wire logic link_clk,
    input wire logic link_tms_in,
    input wire logic link_tdi_in,
    input wire logic link_swd_req,
    input wire logic link_tdo_data,
    input wire logic trace_data,
    input wire logic [7:0] ap_sel,
    input wire logic ap_req,
    // Pin mux
    input wire edfe_pkg::edfe_pins_s gpio_out,
    input wire edfe_pkg::edfe_pins_s gpio_oe,
    output edfe_pkg::edfe_pins_s pin_out,
    output edfe_pkg::edfe_pins_s pin_oe,
    // Access ports and core
    output logic ahb_ap_sel,
    output logic mgr_ap_sel,
    output logic core_reset_req,
    output logic core_halt,
    input wire logic halt_cmd,
    // AXI4-Lite
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import edfe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: mode, pin ownership and external reset sampling.
    logic erst_l1_reg, erst_l2_reg;
    logic rel_seen_reg;
    logic jtag_pins_reg;
    logic ctrl_dbg_en_reg, ctrl_swd_sel_reg, ctrl_trace_en_reg;
    edfe_mode_e mode_reg;
    logic [1:0] swreq_sync_reg;
    logic [1:0] dbg_en_l_reg;
    logic [1:0] swsel_l_reg;

    // External reset sampled by the link clock for pin ownership. The link clock may be parked
    // through the whole reset, so the core reset request is judged on the system clock instead.
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            erst_l1_reg <= 1'b0;
            erst_l2_reg <= 1'b0;
        end else begin
            erst_l1_reg <= ext_reset_b;
            erst_l2_reg <= erst_l1_reg;
        end
    end

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            swreq_sync_reg <= 2'b00;
            dbg_en_l_reg <= 2'b00;
            swsel_l_reg <= 2'b00;
        end else begin
            swreq_sync_reg <= {swreq_sync_reg[0], link_swd_req};
            dbg_en_l_reg <= {dbg_en_l_reg[0], ctrl_dbg_en_reg};
            swsel_l_reg <= {swsel_l_reg[0], ctrl_swd_sel_reg};
        end
    end

    // Pins change owner on the third link clock rising edge after the reset is released, once both sample stages see it.
    wire first_edge = erst_l2_reg && !rel_seen_reg;
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rel_seen_reg <= 1'b0;
            jtag_pins_reg <= 1'b0;
        end else begin
            if (!erst_l2_reg) begin
                rel_seen_reg <= 1'b0;
            end else if (first_edge) begin
                rel_seen_reg <= 1'b1;
                jtag_pins_reg <= 1'b1;
            end
            if (!dbg_en_l_reg[1]) begin
                jtag_pins_reg <= 1'b0;
            end
        end
    end

    // Serial Wire is entered only by the switching sequence or the software select.
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= EDFE_MODE_JTAG;
        end else if (swreq_sync_reg[1] || swsel_l_reg[1]) begin
            mode_reg <= EDFE_MODE_SWD;
        end else begin
            mode_reg <= EDFE_MODE_JTAG;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain.
    logic [2:0] erst_s_reg;
    logic [1:0] lclk_s_reg;
    logic [1:0] pins_sync_reg;
    logic [1:0] swd_sync_reg;
    logic [1:0] sel_sync_reg [8];
    logic [1:0] areq_sync_reg;
    logic [1:0] halt_sync_reg;
    logic core_rst_reg, clk_hi_seen_reg;
    logic [31:0] length_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            erst_s_reg <= 3'h7;
            lclk_s_reg <= 2'h0;
            clk_hi_seen_reg <= 1'b0;
            pins_sync_reg <= 2'h0;
            swd_sync_reg <= 2'h0;
            areq_sync_reg <= 2'h0;
            halt_sync_reg <= 2'h0;
        end else begin
            erst_s_reg <= {erst_s_reg[1:0], ext_reset_b};
            lclk_s_reg <= {lclk_s_reg[0], link_clk};
            // Any high level of the link clock while reset is held cancels the request.
            clk_hi_seen_reg <= !erst_s_reg[1] && (clk_hi_seen_reg || lclk_s_reg[1]);
            pins_sync_reg <= {pins_sync_reg[0], jtag_pins_reg};
            swd_sync_reg <= {swd_sync_reg[0], mode_reg == EDFE_MODE_SWD};
            areq_sync_reg <= {areq_sync_reg[0], ap_req};
            halt_sync_reg <= {halt_sync_reg[0], halt_cmd};
        end
    end

    wire [7:0] sel_val;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sel
            assign sel_val[gi] = sel_sync_reg[gi][1];
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    sel_sync_reg[gi] <= 2'h0;
                end else begin
                    sel_sync_reg[gi] <= {sel_sync_reg[gi][0], ap_sel[gi]};
                end
            end
        end
    endgenerate

    wire req_pulse = erst_s_reg[1] && !erst_s_reg[2] && !clk_hi_seen_reg && !lclk_s_reg[1];
    wire pins_owned = pins_sync_reg[1] && ctrl_dbg_en_reg;
    wire swd_mode = swd_sync_reg[1];
    wire dbg_active = pins_owned && areq_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave. Each channel is accepted alone and the answer follows a cycle later.
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire [7:0] wa = aw_fire ? s_axi_awaddr : aw_addr_reg;
    wire [31:0] wd = w_fire ? s_axi_wdata : w_data_reg;
    wire [3:0] ws = w_fire ? s_axi_wstrb : w_strb_reg;
    wire wr_go = (aw_held_reg || aw_fire) && (w_held_reg || w_fire) && !s_axi_bvalid;
    wire wr_len = wr_go && wa == `EDFE_OFF_LENGTH;
    wire wr_ctl = wr_go && wa == `EDFE_OFF_CTRL;
    wire wr_bad = wr_go && !(wa == `EDFE_OFF_LENGTH || wa == `EDFE_OFF_CTRL || wa == `EDFE_OFF_STAT);
    wire rd_go = s_axi_arvalid && s_axi_arready;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] stat_word = {28'h0000000, pins_owned, swd_mode, core_rst_reg, pins_owned};
    wire [31:0] ctrl_word = {28'h0000000, ctrl_trace_en_reg, ctrl_swd_sel_reg, 1'b0, ctrl_dbg_en_reg};
    wire rd_len = s_axi_araddr == `EDFE_OFF_LENGTH;
    wire rd_ctl = s_axi_araddr == `EDFE_OFF_CTRL;
    wire rd_st = s_axi_araddr == `EDFE_OFF_STAT;
    wire [31:0] rd_word = rd_len ? length_reg : rd_ctl ? ctrl_word : rd_st ? stat_word : 32'h0000_0000;
    wire [31:0] ctl_new = merge(ctrl_word, wd, ws);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EDFE_RESP_OKAY;
        end else begin
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_bad ? `EDFE_RESP_SLVERR : `EDFE_RESP_OKAY;
            end else begin
                if (aw_fire) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (w_fire) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !aw_fire && !s_axi_bvalid && !wr_go;
            s_axi_wready <= !w_held_reg && !w_fire && !s_axi_bvalid && !wr_go;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `EDFE_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_len || rd_ctl || rd_st) ? `EDFE_RESP_OKAY : `EDFE_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and core reset request.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            length_reg <= `EDFE_LENGTH_RST;
            ctrl_dbg_en_reg <= 1'b1;
            ctrl_swd_sel_reg <= 1'b0;
            ctrl_trace_en_reg <= 1'b0;
        end else begin
            if (wr_len) begin
                length_reg <= merge(length_reg, wd, ws) & `EDFE_LENGTH_MASK;
            end
            if (wr_ctl) begin
                ctrl_dbg_en_reg <= ctl_new[`EDFE_CTRL_DBG_EN];
                ctrl_swd_sel_reg <= ctl_new[`EDFE_CTRL_SWD_SEL];
                ctrl_trace_en_reg <= ctl_new[`EDFE_CTRL_TRACE_EN];
            end
        end
    end

    // The external reset line only sets the request, on its release; only the release write clears it,
    // and a new request arriving in the same cycle wins.
    wire rel_wr = wr_ctl && ctl_new[`EDFE_CTRL_RELEASE];
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            core_rst_reg <= 1'b0;
        end else if (req_pulse) begin
            core_rst_reg <= 1'b1;
        end else if (rel_wr) begin
            core_rst_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin multiplexer and access port select outputs.
    edfe_pins_s dbg_out, dbg_oe, mux_out, mux_oe;
    wire trace_on = swd_mode && ctrl_trace_en_reg;
    always_comb begin
        dbg_out = '0;
        dbg_oe = '0;
        dbg_out.tdo_trace = trace_on ? trace_data : link_tdo_data;
        dbg_oe.tdo_trace = trace_on || !swd_mode;
        dbg_out.tms_swdio = link_tms_in;
        dbg_oe.tms_swdio = 1'b0;
    end
    assign mux_out = pins_owned ? dbg_out : gpio_out;
    assign mux_oe = pins_owned ? dbg_oe : gpio_oe;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe <= '0;
            ahb_ap_sel <= 1'b0;
            mgr_ap_sel <= 1'b0;
            core_reset_req <= 1'b0;
            core_halt <= 1'b0;
        end else begin
            pin_out <= mux_out;
            pin_oe <= mux_oe;
            ahb_ap_sel <= dbg_active && sel_val == 8'h00;
            mgr_ap_sel <= dbg_active && sel_val == 8'h01;
            core_reset_req <= core_rst_reg;
            core_halt <= pins_owned && halt_sync_reg[1];
        end
    end
endmodule

// >>> pkg/edfe_defs.svh
`ifndef EDFE_DEFS_SVH
`define EDFE_DEFS_SVH
`define EDFE_OFF_LENGTH 8'h10
`define EDFE_OFF_CTRL 8'h00
`define EDFE_OFF_STAT 8'h04
`define EDFE_LENGTH_RST 32'h0000_0000
`define EDFE_LENGTH_MASK 32'hFFFF_FFFC
`define EDFE_CTRL_DBG_EN 0
`define EDFE_CTRL_RELEASE 1
`define EDFE_CTRL_SWD_SEL 2
`define EDFE_CTRL_TRACE_EN 3
`define EDFE_STAT_CONNECTED 0
`define EDFE_STAT_CORE_RST 1
`define EDFE_STAT_SWD 2
`define EDFE_STAT_JTAG_PINS 3
`define EDFE_RESP_OKAY 2'b00
`define EDFE_RESP_SLVERR 2'b10
`endif

// >>> pkg/edfe_pkg.sv
package edfe_pkg;
    typedef enum logic [1:0] {
        EDFE_MODE_JTAG = 2'b00,
        EDFE_MODE_SWD = 2'b01
    } edfe_mode_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } edfe_wr_s;
    typedef struct packed {
        logic tms_swdio;
        logic tdi;
        logic tdo_trace;
        logic trst;
    } edfe_pins_s;
endpackage
